// *** iptun_control.sv ***
`timescale 1ns/1ps

// Function
// - inner layer ipv4 or ipv6, outer layer always ipv4
// - two rounds; round one loops to virtual device 2 with next leg
// - encapsulating round one: bridge, route inner, strip ethernet, add outer ip/gre
// - decapsulating round one: route outer, strip ethernet, validate, remove outer ip/gre
// - round two routes outer if wrapped, inner if unwrapped, then bridges egress
// - packets between routing stages carry no ethernet, vlan or port
// - multicast rounds have an l2 pass and an l3 virtual device pass
// - non-zero index wraps packet and returns it for outer routing
// - unicast index: action, then next-hop entry, then egress leg; zero unspecified
// - multicast index: mask config when mode is 2, else egress leg
// - no non-zero index means no encapsulation
// - non-zero index looks up the outer template table
// - classifier determines tunnel type of each received frame
// - decapsulate only when leg decapsulation enable is set
// - optional per-leg checks of outer source index and tunnel type
// - decapsulated multicast gets standard ip-to-ethernet multicast mac
// - simple tunnel: one egress leg maps to one tunnel index
// - gre: protocol 47, checksum flag 0, version 0, type by inner version
// - received gre with checksum flag set is accepted
// - plain tunnel: protocol 41 for ipv6, 4 for ipv4
// - added outer header has no options
module iptun_control (
  input  wire logic                       clk,        // core clock
  input  wire logic                       sys_rst,    // synchronous reset
  input  wire logic                       reqValid,   // descriptor offered
  input  wire iptun_pkg::iptun_req_t      req,        // descriptor
  input  wire iptun_pkg::iptun_leg_t      legCfg,     // ingress leg config
  input  wire logic                       tblWrite,   // template write strobe
  input  wire logic [iptun_pkg::IDX_W-1:0] tblAddr,   // template index
  input  wire iptun_pkg::iptun_tmpl_t     tblData,    // template contents
  output logic                            resValid,   // decision ready
  output iptun_pkg::iptun_res_t           res         // decision
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    iptun_pkg::iptun_tmpl_t [iptun_pkg::TBL_DEPTH-1:0] tbl;
    logic                                             valid;
    iptun_pkg::iptun_res_t                            res;
  } iptun_state_t;

  iptun_state_t state;
  iptun_state_t next_state;

  iptun_pkg::iptun_ttype_t    rxType;
  logic                       outerOk;
  logic                       srcOk;
  logic                       typeOk;
  logic                       decapHit;
  logic [iptun_pkg::IDX_W-1:0] selIdx;
  iptun_pkg::iptun_tmpl_t     tmpl;
  logic [15:0]                hdrLen;
  logic [15:0]                totLen;
  logic [7:0]                 proto;
  logic [15:0]                greType;

  // ones-complement header checksum over the ten header words
  function automatic logic [15:0] hdrCsum(input logic [9:0][15:0] w);
    logic [19:0] sum;
    sum = '0;
    for (int i = 0; i < 10; i++) begin
      sum = sum + {4'h0, w[i]};
    end
    sum = {4'h0, sum[15:0]} + {16'h0000, sum[19:16]};
    sum = {4'h0, sum[15:0]} + {16'h0000, sum[19:16]};
    return ~sum[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // classifier: tunnel type and validity of the received outer layer
  always_comb begin
    rxType  = iptun_pkg::TT_NONE;
    outerOk = (req.outerVer == iptun_pkg::IPV4_VER) && (req.outerIhl >= iptun_pkg::IHL_NO_OPTIONS);
    case (req.outerProto)
      iptun_pkg::PROTO_IP4IN4: rxType = iptun_pkg::TT_IP4;
      iptun_pkg::PROTO_IP6IN4: rxType = iptun_pkg::TT_IP6;
      iptun_pkg::PROTO_GRE: begin
        rxType = iptun_pkg::TT_GRE;
        // checksum flag set or clear both accepted, version and type checked
        outerOk = outerOk && (req.greVer == iptun_pkg::GRE_VERSION) &&
                  ((req.greType == iptun_pkg::GRE_TYPE_IP4) || (req.greType == iptun_pkg::GRE_TYPE_IP6));
      end
      default: rxType = iptun_pkg::TT_NONE;
    endcase
  end

  // per-leg decap checks; zero source index disables the source check
  assign srcOk    = (legCfg.srcCheckIdx == iptun_pkg::IDX_NONE) ||
                    (legCfg.srcCheckIdx == req.outerSrcIdx);
  assign typeOk   = !legCfg.typeCheck || (legCfg.allowedType == rxType);
  assign decapHit = !req.round2 && legCfg.decapEnable && (rxType != iptun_pkg::TT_NONE) &&
                    srcOk && typeOk;

  ////////////////////////////////////////////////////////////////////////////
  // encapsulation index precedence, first non-zero wins
  always_comb begin
    selIdx = iptun_pkg::IDX_NONE;
    if (req.mcast) begin
      if (req.mcMaskMode == iptun_pkg::MASK_MODE_ENC && req.mcMaskIdx != iptun_pkg::IDX_NONE) begin
        selIdx = req.mcMaskIdx;
      end else begin
        selIdx = req.legIdx;
      end
    end else if (req.lpmIdx != iptun_pkg::IDX_NONE) begin
      selIdx = req.lpmIdx;
    end else if (req.nextHopIdx != iptun_pkg::IDX_NONE) begin
      selIdx = req.nextHopIdx;
    end else begin
      selIdx = req.legIdx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outer header: template lookup, protocol, length
  assign tmpl    = state.tbl[selIdx];
  assign greType = req.innerIsV6 ? iptun_pkg::GRE_TYPE_IP6 : iptun_pkg::GRE_TYPE_IP4;
  assign hdrLen  = tmpl.useGre ? (iptun_pkg::IP4_HDR_LEN + iptun_pkg::GRE_HDR_LEN) : iptun_pkg::IP4_HDR_LEN;
  assign totLen  = hdrLen + req.innerLen;

  // outer is always ipv4; protocol follows inner version or gre
  always_comb begin
    if (tmpl.useGre) begin
      proto = iptun_pkg::PROTO_GRE;
    end else if (req.innerIsV6) begin
      proto = iptun_pkg::PROTO_IP6IN4;
    end else begin
      proto = iptun_pkg::PROTO_IP4IN4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: template writes and one registered decision per descriptor
  always_comb begin
    next_state       = state;
    next_state.valid = reqValid;
    if (tblWrite) begin
      next_state.tbl[tblAddr] = tblData;
    end
    if (reqValid) begin
      next_state.res          = '0;
      next_state.res.loopVd   = iptun_pkg::VD_NONE;
      next_state.res.ihl      = iptun_pkg::IHL_NO_OPTIONS;
      // multicast: the l3 pass goes via its virtual device, the other bridges
      next_state.res.l2Pass   = !(req.mcast && req.mcL3Pass);
      if (!req.round2) begin
        if (decapHit) begin
          // decap: route outer, strip ethernet, drop if outer layer is bad
          next_state.res.decap      = outerOk;
          next_state.res.drop       = !outerOk;
          next_state.res.routeInner = 1'b0;
          next_state.res.stripEth   = 1'b1;
          if (rxType == iptun_pkg::TT_GRE) begin
            next_state.res.stripLen = iptun_pkg::IP4_HDR_LEN +
                                      (req.greC ? iptun_pkg::GRE_CSUM_LEN : iptun_pkg::GRE_HDR_LEN);
          end else begin
            next_state.res.stripLen = iptun_pkg::IP4_HDR_LEN;
          end
        end else if (selIdx != iptun_pkg::IDX_NONE) begin
          // encap: route inner, strip ethernet, prepend outer header
          next_state.res.encap      = 1'b1;
          next_state.res.encapIdx   = selIdx;
          next_state.res.tmpl       = tmpl;
          next_state.res.routeInner = 1'b1;
          next_state.res.stripEth   = 1'b1;
          next_state.res.outerProto = proto;
          next_state.res.greType    = tmpl.useGre ? greType : iptun_pkg::ZERO_LEN;
          next_state.res.totalLen   = totLen;
          next_state.res.checksum   = hdrCsum({
            {iptun_pkg::IPV4_VER, iptun_pkg::IHL_NO_OPTIONS, tmpl.tos}, totLen,
            iptun_pkg::OUTER_ID_WORD, iptun_pkg::OUTER_FRAG, {tmpl.ttl, proto}, 16'h0000,
            tmpl.srcIp[31:16], tmpl.srcIp[15:0], tmpl.dstIp[31:16], tmpl.dstIp[15:0]});
        end else begin
          // nothing selected: forward unchanged
          next_state.res.routeInner = 1'b1;
        end
        // both tunnel paths come back through the second-round device
        if (next_state.res.encap || next_state.res.decap) begin
          next_state.res.loopVd  = iptun_pkg::VD_SECOND_RND;
          next_state.res.loopLeg = req.nextLeg;
          next_state.res.l2Pass  = 1'b0;
        end
      end else begin
        // round two: wrapped frames route outer, unwrapped route inner
        next_state.res.routeInner = !req.wasEncap;
        next_state.res.l2Pass     = 1'b1;
        if (!req.wasEncap && req.mcast) begin
          next_state.res.dmacValid = 1'b1;
          if (req.innerIsV6) begin
            next_state.res.dmac = {iptun_pkg::MC6_MAC_PREFIX, req.innerDstIp[31:0]};
          end else begin
            next_state.res.dmac = {iptun_pkg::MC4_MAC_PREFIX, req.innerDstIp[22:0]};
          end
        end
      end
    end
  end

  // registered state; the template table survives reset on purpose to spare area
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state.valid <= 1'b0;
      state.res   <= '0;
      state.tbl   <= next_state.tbl;
    end else begin
      state <= next_state;
    end
  end

  assign resValid = state.valid;
  assign res      = state.res;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sRound1Tunnel;
    reqValid && !req.round2 &&
    ((decapHit && outerOk) || (!decapHit && selIdx != iptun_pkg::IDX_NONE));
  endsequence

  sequence sLoopOut;
    resValid && res.loopVd == iptun_pkg::VD_SECOND_RND;
  endsequence

  sequence sUcLpm;
    reqValid && !req.round2 && !decapHit && !req.mcast && req.lpmIdx != iptun_pkg::IDX_NONE;
  endsequence

  sequence sUcNextHop;
    reqValid && !req.round2 && !decapHit && !req.mcast && req.lpmIdx == iptun_pkg::IDX_NONE &&
    req.nextHopIdx != iptun_pkg::IDX_NONE;
  endsequence

  AST_LOOP_SECOND_ROUND: assert property (sRound1Tunnel |=> sLoopOut ##0 res.loopLeg == $past(req.nextLeg))
    else $error("tunnel frame not looped to second round device");

  AST_UC_LPM_FIRST: assert property (sUcLpm |=> res.encap && res.encapIdx == $past(req.lpmIdx))
    else $error("unicast action index not taken first");

  AST_UC_NEXTHOP_SECOND: assert property (sUcNextHop |=> res.encapIdx == $past(req.nextHopIdx))
    else $error("unicast next-hop index not taken second");

  AST_MC_MASK_MODE: assert property (reqValid && !req.round2 && !decapHit && req.mcast &&
    req.mcMaskMode == iptun_pkg::MASK_MODE_ENC && req.mcMaskIdx != iptun_pkg::IDX_NONE
    |=> res.encapIdx == $past(req.mcMaskIdx))
    else $error("multicast mask index not used in mode 2");

  AST_NO_INDEX_NO_ENCAP: assert property (reqValid && !req.round2 && !decapHit && selIdx == iptun_pkg::IDX_NONE
    |=> resValid && !res.encap && res.loopVd == iptun_pkg::VD_NONE)
    else $error("encapsulation added without an index");

  AST_DECAP_NEEDS_ENABLE: assert property (resValid && (res.decap || res.drop) |-> $past(legCfg.decapEnable))
    else $error("decapsulation without leg enable");

  AST_GRE_PROTO: assert property (resValid && res.encap && res.tmpl.useGre |->
    res.outerProto == iptun_pkg::PROTO_GRE && (res.greType == iptun_pkg::GRE_TYPE_IP4 ||
    res.greType == iptun_pkg::GRE_TYPE_IP6))
    else $error("gre outer protocol or type wrong");

  AST_PLAIN_PROTO: assert property (reqValid && !req.round2 && !decapHit && selIdx != iptun_pkg::IDX_NONE &&
    !tmpl.useGre && req.innerIsV6 |=> res.outerProto == iptun_pkg::PROTO_IP6IN4)
    else $error("ipv6 in ipv4 protocol wrong");

  AST_TOTAL_LEN: assert property (sUcLpm ##0 !tmpl.useGre |=> res.totalLen ==
    16'($past(req.innerLen) + iptun_pkg::IP4_HDR_LEN) && res.ihl == iptun_pkg::IHL_NO_OPTIONS)
    else $error("outer total length or header length wrong");

  AST_MC_DMAC: assert property (reqValid && req.round2 && !req.wasEncap && req.mcast && !req.innerIsV6
    |=> res.dmacValid && res.dmac[47:23] == iptun_pkg::MC4_MAC_PREFIX && res.routeInner)
    else $error("decapsulated multicast mac wrong");

  // bad outer layer: dropped, never looped
  sequence sDecapBad;
    reqValid && !req.round2 &&
    decapHit && !outerOk;
  endsequence

  AST_DROP_BAD_OUTER: assert property (
    sDecapBad |=> res.drop &&
    res.loopVd == iptun_pkg::VD_NONE)
    else $error("bad outer layer not dropped");

  // gre checksum word accepted and stripped too
  sequence sGreCsumIn;
    reqValid && !req.round2 && decapHit &&
    outerOk && req.greC &&
    rxType == iptun_pkg::TT_GRE;
  endsequence

  AST_GRE_RX_CSUM: assert property (
    sGreCsumIn |=> res.decap && res.stripLen ==
    iptun_pkg::IP4_HDR_LEN +
    iptun_pkg::GRE_CSUM_LEN)
    else $error("gre with checksum not accepted");

  // round two routes in the domain that round one left
  sequence sRound2;
    reqValid && req.round2;
  endsequence

  AST_ROUND2_ROUTE: assert property (
    sRound2 |=> res.l2Pass && !res.encap &&
    res.routeInner == !$past(req.wasEncap))
    else $error("round two routed in wrong domain");

  // a leg without decap enable never unwraps
  sequence sNoDecapLeg;
    reqValid && !req.round2 &&
    !legCfg.decapEnable;
  endsequence

  AST_DECAP_DISABLED: assert property (
    sNoDecapLeg |=> !res.decap && !res.drop &&
    res.stripLen == iptun_pkg::ZERO_LEN)
    else $error("unwrapped on a disabled leg");

  // multicast l3 copy skips the l2 pass
  sequence sMcL3;
    reqValid && !req.round2 &&
    req.mcast && req.mcL3Pass;
  endsequence

  AST_MC_L3_PASS: assert property (
    sMcL3 |=> !res.l2Pass)
    else $error("multicast l3 copy bridged");

  // gre over an ipv6 inner layer
  sequence sGreV6Out;
    reqValid && !req.round2 &&
    !decapHit && tmpl.useGre &&
    selIdx != iptun_pkg::IDX_NONE &&
    req.innerIsV6;
  endsequence

  AST_GRE_TYPE_V6: assert property (
    sGreV6Out |=> res.greType ==
    iptun_pkg::GRE_TYPE_IP6)
    else $error("gre type wrong for ipv6");

endmodule

// *** iptun_pkg.sv ***
package iptun_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and table geometry
  localparam int IDX_W     = 4;
  localparam int TBL_DEPTH = 16;
  localparam int LEG_W     = 8;

  ////////////////////////////////////////////////////////////////////////////
  // header encodings
  localparam logic [3:0]  IPV4_VER       = 4'h4;
  localparam logic [3:0]  IHL_NO_OPTIONS = 4'h5;
  localparam logic [7:0]  PROTO_GRE      = 8'h2f;
  localparam logic [7:0]  PROTO_IP4IN4   = 8'h04;
  localparam logic [7:0]  PROTO_IP6IN4   = 8'h29;
  localparam logic [15:0] GRE_TYPE_IP4   = 16'h0800;
  localparam logic [15:0] GRE_TYPE_IP6   = 16'h86dd;
  localparam logic [2:0]  GRE_VERSION    = 3'h0;
  localparam logic [15:0] GRE_FLAGS_WORD = 16'h0000;
  localparam logic [15:0] OUTER_ID_WORD  = 16'h0000;
  localparam logic [15:0] OUTER_FRAG     = 16'h0000;
  localparam logic [15:0] IP4_HDR_LEN    = 16'h0014;
  localparam logic [15:0] GRE_HDR_LEN    = 16'h0004;
  localparam logic [15:0] GRE_CSUM_LEN   = 16'h0008;
  localparam logic [15:0] ZERO_LEN       = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // virtual devices, mask mode, multicast mac mapping
  localparam logic [1:0]  VD_MC_L3       = 2'h0;
  localparam logic [1:0]  VD_SECOND_RND  = 2'h2;
  localparam logic [1:0]  VD_NONE        = 2'h3;
  localparam logic [1:0]  MASK_MODE_ENC  = 2'h2;
  localparam logic [24:0] MC4_MAC_PREFIX = 25'h0200bc;
  localparam logic [15:0] MC6_MAC_PREFIX = 16'h3333;
  localparam logic [IDX_W-1:0] IDX_NONE  = 4'h0;

  // tunnel type seen by the frame classifier, one-hot
  typedef enum logic [3:0] {
    TT_NONE = 4'b0001,
    TT_IP4  = 4'b0010,
    TT_IP6  = 4'b0100,
    TT_GRE  = 4'b1000
  } iptun_ttype_t;

  // one frame descriptor offered to the block
  typedef struct packed {
    logic             round2;      // second processing round
    logic             wasEncap;    // round two: frame was wrapped in round one
    logic             mcast;       // inner ip multicast
    logic             mcL3Pass;    // multicast pass through the l3 virtual device
    logic             innerIsV6;   // inner layer is ipv6
    logic [15:0]      innerLen;    // inner ip packet length in bytes
    logic [127:0]     innerDstIp;  // inner destination address, ipv4 in low bits
    logic [IDX_W-1:0] lpmIdx;      // next-hop action index
    logic [IDX_W-1:0] nextHopIdx;  // next-hop table index
    logic [IDX_W-1:0] legIdx;      // egress leg index
    logic [1:0]       mcMaskMode;  // per-leg multicast mask mode
    logic [IDX_W-1:0] mcMaskIdx;   // per-leg multicast mask index
    logic [3:0]       outerVer;    // parsed outer version
    logic [3:0]       outerIhl;    // parsed outer header length
    logic [7:0]       outerProto;  // parsed outer protocol
    logic             greC;        // parsed gre checksum flag
    logic [2:0]       greVer;      // parsed gre version
    logic [15:0]      greType;     // parsed gre protocol type
    logic [IDX_W-1:0] outerSrcIdx; // index that the outer source matched
    logic [LEG_W-1:0] nextLeg;     // leg for the second round
  } iptun_req_t;

  // router leg decapsulation configuration
  typedef struct packed {
    logic             decapEnable;
    logic [IDX_W-1:0] srcCheckIdx; // zero disables the source check
    logic             typeCheck;
    iptun_ttype_t     allowedType;
  } iptun_leg_t;

  // one outer ipv4 template entry
  typedef struct packed {
    logic [31:0] srcIp;
    logic [31:0] dstIp;
    logic [7:0]  ttl;
    logic [7:0]  tos;
    logic        useGre;
  } iptun_tmpl_t;

  // decision and outer header for one frame
  typedef struct packed {
    logic             encap;
    logic             decap;
    logic             drop;
    logic [IDX_W-1:0] encapIdx;
    iptun_tmpl_t      tmpl;
    logic [3:0]       ihl;
    logic [7:0]       outerProto;
    logic [15:0]      greType;
    logic [15:0]      totalLen;
    logic [15:0]      checksum;
    logic [15:0]      stripLen;
    logic             stripEth;
    logic             routeInner;
    logic             l2Pass;
    logic [1:0]       loopVd;
    logic [LEG_W-1:0] loopLeg;
    logic             dmacValid;
    logic [47:0]      dmac;
  } iptun_res_t;

endpackage

// *** iptun_remote_rtr.sv ***
`timescale 1ns/1ps
// far-end router: builds the outer layer that it sends into the tunnel
module iptun_remote_rtr (
  input  wire logic [1:0] kind,    // 0 ip4, 1 ip6, 2 gre
  input  wire logic       csumOn,  // gre checksum word present
  input  wire logic       innerV6, // inner layer ipv6
  output logic [7:0]      proto,   // outer protocol
  output logic            greC,    // gre checksum flag
  output logic [2:0]      greVer,  // gre version
  output logic [15:0]     greType  // gre protocol type
);
  // a real peer may send the checksum word, so the flag is not forced low
  always_comb begin
    proto   = (kind == 2'h2) ? 8'h2f : (kind == 2'h1) ? 8'h29 : 8'h04;
    greC    = (kind == 2'h2) && csumOn;
    greVer  = 3'h0;
    greType = innerV6 ? 16'h86dd : 16'h0800;
  end
endmodule

// *** ip_in_ipv4_tunnel_control_tb_top.sv ***
`timescale 1ns/1ps
module ip_in_ipv4_tunnel_control_tb_top;
  typedef struct packed {
    logic e, d, x, se, ri, l2, dv;
    logic [3:0] i, h;
    logic [7:0] p, lg;
    logic [15:0] g, l, c, s;
    logic [1:0] v;
    logic [47:0] m;
    iptun_pkg::iptun_tmpl_t t;
  } iptun_chk_t;
  logic                    clk, sys_rst, reqValid, tblWrite, resValid, csumOn, innerV6, rC;
  logic [1:0]              kind;
  logic [2:0]              rVer;
  logic [3:0]              tblAddr;
  logic [7:0]              rProto;
  logic [15:0]             rType;
  iptun_pkg::iptun_req_t   req, r;
  iptun_pkg::iptun_leg_t   legCfg, g;
  iptun_pkg::iptun_tmpl_t  tblData, tm;
  iptun_pkg::iptun_res_t   res;
  iptun_pkg::iptun_tmpl_t  mirror [16];
  iptun_chk_t              expQ [$];
  iptun_chk_t              got, want;
  int                      errors, cmp_count;

  iptun_control iptun_control_i (.clk(clk), .sys_rst(sys_rst), .reqValid(reqValid), .req(req), .legCfg(legCfg),
    .tblWrite(tblWrite), .tblAddr(tblAddr), .tblData(tblData), .resValid(resValid), .res(res));
  iptun_remote_rtr iptun_remote_rtr_i (.kind(kind), .csumOn(csumOn), .innerV6(innerV6), .proto(rProto),
    .greC(rC), .greVer(rVer), .greType(rType));

  ////////////////////////////////////////////////////////////////////////////
  // ones-complement sum over the ten header words, id and frag zero
  function automatic logic [15:0] csum(iptun_pkg::iptun_tmpl_t t, logic [7:0] p, logic [15:0] l);
    logic [31:0] s;
    s = {16'h0, 8'h45, t.tos} + {16'h0, l} + {16'h0, t.ttl, p} + t.srcIp[31:16] + t.srcIp[15:0]
      + t.dstIp[31:16] + t.dstIp[15:0];
    s = s[31:16] + s[15:0];
    s = s[31:16] + s[15:0];
    return ~s[15:0];
  endfunction

  // reference decision; only fields that mean something are filled
  function automatic iptun_chk_t model(iptun_pkg::iptun_req_t r, iptun_pkg::iptun_leg_t g);
    iptun_chk_t k;
    iptun_pkg::iptun_ttype_t tt;
    logic [3:0] ix;
    logic gr;
    k = '0;
    k.v = iptun_pkg::VD_NONE;
    k.ri = 1'b1;
    k.l2 = !(r.mcast && r.mcL3Pass);
    if (r.round2) begin
      k.ri = !r.wasEncap;
      k.l2 = 1'b1;
      k.dv = !r.wasEncap && r.mcast;
      if (k.dv) k.m = r.innerIsV6 ? {iptun_pkg::MC6_MAC_PREFIX, r.innerDstIp[31:0]}
                                  : {iptun_pkg::MC4_MAC_PREFIX, r.innerDstIp[22:0]};
      return k;
    end
    case (r.outerProto)
      8'h04:   tt = iptun_pkg::TT_IP4;
      8'h29:   tt = iptun_pkg::TT_IP6;
      8'h2f:   tt = iptun_pkg::TT_GRE;
      default: tt = iptun_pkg::TT_NONE;
    endcase
    if (g.decapEnable && tt != iptun_pkg::TT_NONE && (g.srcCheckIdx == 4'h0 || g.srcCheckIdx == r.outerSrcIdx)
        && (!g.typeCheck || g.allowedType == tt)) begin
      k.d = r.outerVer == 4'h4 && r.outerIhl >= 4'h5 && (tt != iptun_pkg::TT_GRE || (r.greVer == 3'h0
            && (r.greType == iptun_pkg::GRE_TYPE_IP4 || r.greType == iptun_pkg::GRE_TYPE_IP6)));
      k.x = !k.d;
      k.ri = 1'b0;
      k.se = 1'b1;
      k.s = iptun_pkg::IP4_HDR_LEN + ((tt != iptun_pkg::TT_GRE) ? iptun_pkg::ZERO_LEN
          : r.greC ? iptun_pkg::GRE_CSUM_LEN : iptun_pkg::GRE_HDR_LEN);
      if (k.d) begin
        k.v = iptun_pkg::VD_SECOND_RND;
        k.lg = r.nextLeg;
        k.l2 = 1'b0;
      end
      return k;
    end
    ix = r.mcast ? ((r.mcMaskMode == iptun_pkg::MASK_MODE_ENC && r.mcMaskIdx != 4'h0) ? r.mcMaskIdx : r.legIdx)
       : (r.lpmIdx != 4'h0) ? r.lpmIdx : (r.nextHopIdx != 4'h0) ? r.nextHopIdx : r.legIdx;
    if (ix != 4'h0) begin
      gr = mirror[ix].useGre;
      k.e = 1'b1;
      k.se = 1'b1;
      k.i = ix;
      k.t = mirror[ix];
      k.h = iptun_pkg::IHL_NO_OPTIONS;
      k.p = gr ? iptun_pkg::PROTO_GRE : r.innerIsV6 ? iptun_pkg::PROTO_IP6IN4 : iptun_pkg::PROTO_IP4IN4;
      k.g = !gr ? iptun_pkg::ZERO_LEN : r.innerIsV6 ? iptun_pkg::GRE_TYPE_IP6 : iptun_pkg::GRE_TYPE_IP4;
      k.l = iptun_pkg::IP4_HDR_LEN + (gr ? iptun_pkg::GRE_HDR_LEN : iptun_pkg::ZERO_LEN) + r.innerLen;
      k.c = csum(mirror[ix], k.p, k.l);
      k.v = iptun_pkg::VD_SECOND_RND;
      k.lg = r.nextLeg;
      k.l2 = 1'b0;
    end
    return k;
  endfunction

  // observed decision, masked the same way as the reference
  function automatic iptun_chk_t obs(iptun_pkg::iptun_res_t s);
    iptun_chk_t k;
    k = '0;
    k.e = s.encap;
    k.d = s.decap;
    k.x = s.drop;
    k.v = s.loopVd;
    k.ri = s.routeInner;
    k.l2 = s.l2Pass;
    k.dv = s.dmacValid;
    if (s.encap || s.decap || s.drop) k.se = s.stripEth;
    if (s.encap) {k.i, k.t, k.h, k.p, k.g, k.l, k.c} = {s.encapIdx, s.tmpl, s.ihl, s.outerProto, s.greType,
      s.totalLen, s.checksum};
    if (s.decap || s.drop) k.s = s.stripLen;
    if (s.loopVd == iptun_pkg::VD_SECOND_RND) k.lg = s.loopLeg;
    if (s.dmacValid) k.m = s.dmac;
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // driver side: offer one descriptor and note what must come back
  task automatic send(iptun_pkg::iptun_req_t rq, iptun_pkg::iptun_leg_t lc);
    @(negedge clk);
    reqValid = 1'b1;
    req = rq;
    legCfg = lc;
    expQ.push_back(model(rq, lc));
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // zero index at least a third of the time so the fallbacks get exercised
  function automatic logic [3:0] r4();
    return ($urandom % 3 == 0) ? 4'h0 : 4'($urandom);
  endfunction

  // outer version, length, gre version and type are made bad at random; callers override fields as needed
  function automatic iptun_pkg::iptun_req_t rreq();
    iptun_pkg::iptun_req_t q;
    logic [7:0] pl [4];
    pl = '{8'h04, 8'h29, 8'h2f, 8'h11};
    q = '0;
    {q.mcast, q.mcL3Pass, q.innerIsV6, q.wasEncap, q.greC} = 5'($urandom);
    q.round2 = ($urandom % 4 == 0);
    q.innerLen = 16'($urandom % 1500);
    q.innerDstIp = {$urandom, $urandom, $urandom, $urandom};
    {q.lpmIdx, q.nextHopIdx, q.legIdx, q.mcMaskIdx} = {r4(), r4(), r4(), r4()};
    q.mcMaskMode = 2'($urandom);
    q.outerVer = ($urandom % 5 == 0) ? 4'h6 : 4'h4;
    q.outerIhl = ($urandom % 5 == 0) ? 4'h4 : 4'h5;
    q.outerProto = pl[$urandom % 4];
    q.greVer = ($urandom % 6 == 0) ? 3'h1 : 3'h0;
    q.greType = ($urandom % 6 == 0) ? 16'h0806 : 16'h0800;
    q.outerSrcIdx = 4'($urandom % 4);
    q.nextLeg = 8'($urandom);
    return q;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // monitor: each decision is matched against the oldest note
  always @(negedge clk) begin
    if (resValid === 1'b1) begin
      got = obs(res);
      want = (expQ.size() != 0) ? expQ.pop_front() : '1;
      cmp_count++;
      if (got !== want) begin
        errors++;
        $display("BAD %0t got %h exp %h", $time, got, want);
      end
    end
  end

  // hang guard well above the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end

  initial begin
    {sys_rst, reqValid, tblWrite, tblAddr, kind, csumOn, innerV6} = 11'h400;
    {req, legCfg, tblData} = '0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(79));
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    cmp_count++;
    if (resValid !== 1'b0 || res !== '0) begin
      errors++;
      $display("BAD %0t reset %h %h", $time, resValid, res);
    end
    // fill every template; odd entries use gre, back to back writes
    for (int i = 0; i < 16; i++) begin
      tm = {$urandom, $urandom, 16'($urandom), i[0]};
      @(negedge clk);
      {tblWrite, tblAddr, tblData} = {1'b1, 4'(i), tm};
      mirror[i] = tm;
    end
    @(negedge clk);
    tblWrite = 1'b0;
    // unicast precedence over every mix of sources; multicast over mask modes with mask and leg index both set or both zero
    for (int i = 0; i < 16; i++) begin
      r = rreq();
      {r.round2, r.mcast, r.outerProto, r.legIdx} = {1'b0, i[3], 8'h11, i[2] ? 4'h9 : 4'h0};
      {r.lpmIdx, r.nextHopIdx} = {i[0] ? 4'h3 : 4'h0, i[1] ? 4'h6 : 4'h0};
      {r.mcMaskMode, r.mcMaskIdx} = {i[1:0], i[2] ? 4'h5 : 4'h0};
      send(r, '0);
    end
    // every tunnel kind from the peer, with and without gre checksum
    for (int k = 0; k < 6; k++) begin
      {kind, csumOn, innerV6} = {2'(k % 3), k > 2, k % 3 == 1};
      #1;
      r = rreq();
      {r.round2, r.outerVer, r.outerIhl, r.outerSrcIdx} = {1'b0, 4'h4, 4'h5, 4'h2};
      {r.outerProto, r.greC, r.greVer, r.greType} = {rProto, rC, rVer, rType};
      g = {1'b1, 4'h2, 1'b1, iptun_pkg::iptun_ttype_t'(4'h2 << kind)};
      send(r, g);
      g.decapEnable = 1'b0;
      send(r, g);
      {r.round2, r.wasEncap, r.mcast} = 3'b101;
      send(r, g);
    end
    // random traffic, mostly back to back
    for (int n = 0; n < 300; n++) begin
      g = {1'($urandom % 4 != 0), 4'($urandom % 4), 1'($urandom), iptun_pkg::iptun_ttype_t'(4'h1 << ($urandom % 4))};
      send(rreq(), g);
      if ($urandom % 5 == 0) begin
        @(negedge clk);
        reqValid = 1'b0;
      end
    end
    @(negedge clk);
    reqValid = 1'b0;
    for (int n = 0; n < 20 && expQ.size() != 0; n++) @(negedge clk);
    if (expQ.size() != 0) begin
      errors++;
      $display("BAD %0t missing %h %h", $time, expQ.size(), 0);
    end
    summarize();
  end
endmodule
